// ---- logic/nvh_pkg.sv ----
// constants and types shared by the nvsram host controller
package nvh_pkg;
    localparam int unsigned ADDR_W = 17;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MATCH_W = 16;
    localparam logic [2:0] SEQ_LAST = 3'h6 - 3'h1;

    localparam logic [15:0] SEQ_A0 = 16'h4E38;
    localparam logic [15:0] SEQ_A1 = 16'hB1C7;
    localparam logic [15:0] SEQ_A2 = 16'h83E0;
    localparam logic [15:0] SEQ_A3 = 16'h7C1F;
    localparam logic [15:0] SEQ_A4 = 16'h703F;
    localparam logic [15:0] SEQ_STORE = 16'h8FC0;
    localparam logic [15:0] SEQ_RECALL = 16'h4C63;
    localparam logic [15:0] SEQ_AS_EN = 16'h4B46;
    localparam logic [15:0] SEQ_AS_DIS = 16'h8B45;

    localparam int unsigned CLK_NS = 4;
    localparam int unsigned ACC_NS = 45;
    localparam int unsigned GAP_NS = 25;
    localparam int unsigned ACC_CYC_I = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned GAP_CYC_I = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] ACC_CYC = 8'(ACC_CYC_I);
    localparam logic [7:0] GAP_CYC = 8'(GAP_CYC_I);
    localparam int unsigned NV_WAIT_CYC_DEF = 12500;

    typedef enum logic [2:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_STORE,
        CMD_RECALL,
        CMD_AS_EN,
        CMD_AS_DIS
    } nvh_cmd_t;

    typedef enum logic [1:0] {
        CY_IDLE,
        CY_ACT,
        CY_GAP
    } nvh_cyc_t;

    typedef enum logic [2:0] {
        M_RST,
        M_IDLE,
        M_SEQ,
        M_ACC,
        M_WAIT
    } nvh_main_t;
endpackage

// ---- logic/nvh_bus_cycle.sv ----
// one chip-select access cycle on the asynchronous memory pins
`timescale 1ns/1ps
module nvh_bus_cycle (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic wr,
    input wire logic use_oe,
    input wire logic [nvh_pkg::ADDR_W-1:0] addr_in,
    input wire logic [nvh_pkg::DATA_W-1:0] wdata,
    output logic idle,
    output logic done_r,
    output logic [nvh_pkg::DATA_W-1:0] rdata_r,
    output logic ce_n_r,
    output logic we_n_r,
    output logic oe_n_r,
    output logic [nvh_pkg::ADDR_W-1:0] addr_r,
    output logic [nvh_pkg::DATA_W-1:0] dq_out_r,
    output logic dq_oe_r,
    input wire logic [nvh_pkg::DATA_W-1:0] dq_in
);
    import nvh_pkg::*;

    nvh_cyc_t state_r;
    logic [7:0] cnt_r;
    logic wr_r;
    logic use_oe_r;
    logic [DATA_W-1:0] d1_r;
    logic [DATA_W-1:0] d2_r;
    logic [DATA_W-1:0] d3_r;
    logic [7:0] low_cnt_r;
    wire stable = (d2_r == d3_r);
    wire cnt_zero = (cnt_r == 8'h00);
    wire act_end = (state_r == CY_ACT) && cnt_zero && (wr_r || !use_oe_r || stable);

    assign idle = (state_r == CY_IDLE);

    // data pins are asynchronous to clk_sys
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            d1_r <= '0;
            d2_r <= '0;
            d3_r <= '0;
        end else begin
            d1_r <= dq_in;
            d2_r <= d1_r;
            d3_r <= d2_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= CY_IDLE;
            cnt_r <= 8'h00;
            wr_r <= 1'b0;
            use_oe_r <= 1'b0;
            ce_n_r <= 1'b1;
            we_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            addr_r <= '0;
            dq_out_r <= '0;
            dq_oe_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            done_r <= 1'b0;
            unique case (state_r)
                CY_IDLE: begin
                    if (start) begin
                        // each access gets its own chip-select falling edge
                        state_r <= CY_ACT;
                        cnt_r <= ACC_CYC - 8'h01;
                        wr_r <= wr;
                        use_oe_r <= use_oe;
                        addr_r <= addr_in;
                        dq_out_r <= wdata;
                        ce_n_r <= 1'b0;
                        we_n_r <= !wr;
                        oe_n_r <= wr || !use_oe;
                        dq_oe_r <= wr;
                    end
                end
                CY_ACT: begin
                    if (!cnt_zero) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else if (act_end) begin
                        if (!wr_r && use_oe_r) begin
                            rdata_r <= d3_r;
                        end
                        ce_n_r <= 1'b1;
                        we_n_r <= 1'b1;
                        oe_n_r <= 1'b1;
                        state_r <= CY_GAP;
                        cnt_r <= GAP_CYC - 8'h01;
                    end
                end
                CY_GAP: begin
                    if (!cnt_zero) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else begin
                        // write data held through the gap for hold time
                        dq_oe_r <= 1'b0;
                        state_r <= CY_IDLE;
                        done_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    // helper: length of the chip-select low phase
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            low_cnt_r <= 8'h00;
        end else if (!ce_n_r) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end else begin
            low_cnt_r <= 8'h00;
        end
    end

    acc_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(ce_n_r) |-> $past(low_cnt_r) >= ACC_CYC - 8'h01)
        else $error("chip select low phase too short");
    gap_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(ce_n_r) |-> ce_n_r [*7])
        else $error("chip select high gap too short");
    write_pins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !we_n_r |-> oe_n_r && dq_oe_r && !ce_n_r)
        else $error("write strobe without data drive or with output gate");
    done_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        done_r |-> ce_n_r && we_n_r ##1 !done_r)
        else $error("done not a single pulse with pins idle");
endmodule

// ---- logic/nvh_nvsram_host.sv ----
// host controller issuing accesses and mode sequences to an nvsram
`timescale 1ns/1ps
module nvh_nvsram_host #(
    parameter int unsigned NV_WAIT_CYC = nvh_pkg::NV_WAIT_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic autosave_keep_on,
    input wire logic cmd_valid,
    input wire nvh_pkg::nvh_cmd_t cmd_code,
    input wire logic [nvh_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [nvh_pkg::DATA_W-1:0] cmd_wdata,
    output logic cmd_ready_r,
    output logic rsp_valid_r,
    output logic [nvh_pkg::DATA_W-1:0] rsp_rdata_r,
    output logic init_done_r,
    output logic mem_ce_n,
    output logic mem_we_n,
    output logic mem_oe_n,
    output logic [nvh_pkg::ADDR_W-1:0] mem_addr,
    output logic [nvh_pkg::DATA_W-1:0] mem_dq_out,
    output logic mem_dq_oe,
    input wire logic [nvh_pkg::DATA_W-1:0] mem_dq_in
);
    import nvh_pkg::*;

    function automatic logic [MATCH_W-1:0] mode_code(input nvh_cmd_t op);
        logic [MATCH_W-1:0] c;
        c = SEQ_STORE;
        unique case (op)
            CMD_STORE: c = SEQ_STORE;
            CMD_RECALL: c = SEQ_RECALL;
            CMD_AS_EN: c = SEQ_AS_EN;
            CMD_AS_DIS: c = SEQ_AS_DIS;
            default: c = SEQ_STORE;
        endcase
        return c;
    endfunction

    function automatic logic [MATCH_W-1:0] seq_addr(input logic [2:0] idx, input nvh_cmd_t op);
        logic [MATCH_W-1:0] a;
        a = SEQ_A0;
        unique case (idx)
            3'h0: a = SEQ_A0;
            3'h1: a = SEQ_A1;
            3'h2: a = SEQ_A2;
            3'h3: a = SEQ_A3;
            3'h4: a = SEQ_A4;
            default: a = mode_code(op);
        endcase
        return a;
    endfunction

    nvh_main_t state_r;
    nvh_cmd_t op_r;
    logic [2:0] idx_r;
    logic issued_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [23:0] wait_r;
    logic cyc_idle;
    logic cyc_done;
    logic [DATA_W-1:0] cyc_rdata;
    logic autosave_keep_on_q;

    wire in_seq = (state_r == M_SEQ);
    wire in_acc = (state_r == M_ACC);
    wire nv_op = (op_r == CMD_STORE) || (op_r == CMD_RECALL);
    wire last_step = (idx_r == SEQ_LAST);
    // host never breaks a sequence with another access
    wire cyc_start = (in_seq || in_acc) && !issued_r && cyc_idle;
    // top address line driven low: only sixteen lines are matched
    wire [ADDR_W-1:0] cyc_addr = in_seq ? {1'b0, seq_addr(idx_r, op_r)} : addr_r;
    wire cyc_wr = in_acc && (op_r == CMD_WRITE);
    // sixth save or recall read carries no data: gate stays high
    wire cyc_use_oe = in_acc || !(last_step && nv_op);
    // plain accesses let the caller set contents and a saved signature
    wire is_mem_cmd = (cmd_code == CMD_READ) || (cmd_code == CMD_WRITE);
    wire take = (state_r == M_IDLE) && cmd_valid && cmd_ready_r;
    wire wait_zero = (wait_r == 24'h00_0000);

    nvh_bus_cycle u_cycle (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(cyc_start),
        .wr(cyc_wr),
        .use_oe(cyc_use_oe),
        .addr_in(cyc_addr),
        .wdata(wdata_r),
        .idle(cyc_idle),
        .done_r(cyc_done),
        .rdata_r(cyc_rdata),
        .ce_n_r(mem_ce_n),
        .we_n_r(mem_we_n),
        .oe_n_r(mem_oe_n),
        .addr_r(mem_addr),
        .dq_out_r(mem_dq_out),
        .dq_oe_r(mem_dq_oe),
        .dq_in(mem_dq_in)
    );

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            issued_r <= 1'b0;
        end else if (cyc_start) begin
            issued_r <= 1'b1;
        end else if (cyc_done) begin
            issued_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= M_RST;
            op_r <= CMD_READ;
            idx_r <= 3'h0;
            addr_r <= '0;
            wdata_r <= '0;
            wait_r <= 24'h00_0000;
            cmd_ready_r <= 1'b0;
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= '0;
            init_done_r <= 1'b0;
        end else begin
            rsp_valid_r <= 1'b0;
            unique case (state_r)
                M_RST: begin
                    // mode strap caught after release, sequence sent each reset
                    op_r <= autosave_keep_on ? CMD_AS_EN : CMD_AS_DIS;
                    idx_r <= 3'h0;
                    state_r <= M_SEQ;
                end
                M_IDLE: begin
                    if (take) begin
                        op_r <= cmd_code;
                        addr_r <= cmd_addr;
                        wdata_r <= cmd_wdata;
                        idx_r <= 3'h0;
                        cmd_ready_r <= 1'b0;
                        state_r <= is_mem_cmd ? M_ACC : M_SEQ;
                    end
                end
                M_SEQ: begin
                    if (cyc_done) begin
                        if (!last_step) begin
                            idx_r <= idx_r + 3'h1;
                        end else if (nv_op) begin
                            // save or recall: stay off the bus until done
                            wait_r <= 24'(NV_WAIT_CYC - 1);
                            state_r <= M_WAIT;
                        end else begin
                            // auto save mode change has no busy time
                            state_r <= M_IDLE;
                            cmd_ready_r <= 1'b1;
                            rsp_valid_r <= init_done_r;
                            init_done_r <= 1'b1;
                        end
                    end
                end
                M_ACC: begin
                    if (cyc_done) begin
                        // data passed on as read, no preset pattern assumed
                        rsp_rdata_r <= cyc_rdata;
                        rsp_valid_r <= 1'b1;
                        cmd_ready_r <= 1'b1;
                        state_r <= M_IDLE;
                    end
                end
                M_WAIT: begin
                    if (!wait_zero) begin
                        wait_r <= wait_r - 24'h00_0001;
                    end else begin
                        // next access starts with chip select high
                        state_r <= M_IDLE;
                        cmd_ready_r <= 1'b1;
                        rsp_valid_r <= 1'b1;
                    end
                end
                default: state_r <= M_RST;
            endcase
        end
    end

    seq_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(mem_ce_n) && in_seq |-> mem_addr == {1'b0, seq_addr(idx_r, op_r)})
        else $error("sequence address out of order");
    seq_no_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        in_seq |-> mem_we_n && !mem_dq_oe)
        else $error("write strobe low inside mode sequence");
    store_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(mem_ce_n) && in_seq && last_step && op_r == CMD_STORE
        |-> mem_addr[15:0] == SEQ_STORE && mem_oe_n)
        else $error("save sequence does not end at save code");
    recall_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        in_seq && last_step && cyc_done && op_r == CMD_RECALL
        |=> state_r == M_WAIT && mem_ce_n)
        else $error("recall sequence not followed by busy wait");
    enable_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(mem_ce_n) && in_seq && last_step && op_r == CMD_AS_EN
        |-> mem_addr[15:0] == SEQ_AS_EN)
        else $error("enable sequence ends at wrong code");
    disable_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(mem_ce_n) && in_seq && last_step && op_r == CMD_AS_DIS
        |-> mem_addr[15:0] == SEQ_AS_DIS && !mem_oe_n)
        else $error("disable sequence ends at wrong code");
    reset_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == M_RST |=> in_seq && idx_r == 3'h0
        && op_r == (autosave_keep_on_q ? CMD_AS_EN : CMD_AS_DIS))
        else $error("reset does not issue auto save mode sequence");
    nv_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == M_WAIT |-> mem_ce_n && !cmd_ready_r)
        else $error("bus active during nonvolatile busy time");

    // helper: strap value seen by the reset state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            autosave_keep_on_q <= 1'b0;
        end else begin
            autosave_keep_on_q <= autosave_keep_on;
        end
    end
endmodule

// ---- dv/nvh_nvsram_model.sv ----
// behavioural nvsram device model facing the host controller
`timescale 1ns/1ps
module nvh_nvsram_model #(
    parameter int T_BUSY = 16
) (
    input wire logic clk_sys,
    input wire logic mem_ce_n,
    input wire logic mem_we_n,
    input wire logic mem_oe_n,
    input wire logic [nvh_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [nvh_pkg::DATA_W-1:0] host_dq,
    input wire logic host_oe,
    input wire logic [3:0] rd_lat,
    output logic [nvh_pkg::DATA_W-1:0] dq_lvl
);
    import nvh_pkg::*;
    localparam logic [15:0] SEQ_PRE [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    logic [7:0] mem [int];
    logic [7:0] nv [int];
    logic as_en = 1'b1;
    int store_cnt = 0;
    int recall_cnt = 0;
    int abort_cnt = 0;
    int seq_wr = 0;
    int busy_hit = 0;
    int clash = 0;
    int step = 0;
    int busy = 0;
    int acc = 0;
    logic ce_q = 1'b1;
    logic we_q = 1'b1;
    logic wr_seen = 1'b0;
    logic blk = 1'b0;
    logic [ADDR_W-1:0] a_q = '0;
    logic [7:0] wd_q = 8'h00;
    logic [7:0] flt = 8'h5A;
    logic [7:0] val = 8'h00;
    logic drv = 1'b0;
    // sixth save or recall read leaves the pins floating
    wire hz6 = step == 5 && (mem_addr[15:0] == SEQ_STORE || mem_addr[15:0] == SEQ_RECALL);
    wire rd_on = !mem_ce_n && !mem_oe_n && mem_we_n && busy == 0 && !hz6;
    // undriven pins toggle every cycle
    assign dq_lvl = host_oe ? host_dq : (drv ? val : flt);

    // unprogrammed cells hold an arbitrary pattern
    function automatic logic [7:0] peek(input int k);
        return mem.exists(k) ? mem[k] : (8'(k) ^ 8'hA5);
    endfunction

    task automatic fin();
        logic [15:0] k;
        k = a_q[15:0];
        if (wr_seen) begin
            if (!blk)
                mem[int'(a_q)] = wd_q;
            if (step > 0)
                seq_wr++;
            step = 0;
        end else if (step == 5) begin
            step = 0;
            if (k == SEQ_STORE) begin
                nv = mem;
                store_cnt++;
                busy = T_BUSY;
            end else if (k == SEQ_RECALL) begin
                mem.delete();
                mem = nv;
                recall_cnt++;
                busy = T_BUSY;
            end else if (k == SEQ_AS_EN) begin
                as_en = 1'b1;
            end else if (k == SEQ_AS_DIS) begin
                as_en = 1'b0;
            end else begin
                abort_cnt++;
            end
        end else if (k == SEQ_PRE[step]) begin
            step++;
        end else begin
            if (step > 0)
                abort_cnt++;
            step = (k == SEQ_PRE[0]) ? 1 : 0;
        end
        wr_seen = 1'b0;
    endtask

    always @(posedge clk_sys) begin
        flt <= ~flt;
        drv <= rd_on && acc >= int'(rd_lat);
        val <= peek(int'(mem_addr));
        if ((ce_q && !mem_ce_n) || (we_q && !mem_we_n))
            blk = 1'b0;
        if (busy > 0) begin
            busy--;
            if (!mem_ce_n)
                busy_hit++;
            if (busy == 0 && !mem_ce_n && !mem_we_n)
                blk = 1'b1;
        end else if (!ce_q && mem_ce_n) begin
            fin();
        end
        if (!mem_ce_n) begin
            acc++;
            wr_seen = wr_seen | !mem_we_n;
            a_q = mem_addr;
            if (!mem_we_n)
                wd_q = host_dq;
            if (host_oe && drv)
                clash++;
        end else begin
            acc = 0;
        end
        ce_q = mem_ce_n;
        we_q = mem_we_n;
    end
endmodule

// ---- dv/nvh_nvsram_host_tb.sv ----
// self-checking bench for the nvsram host controller
`timescale 1ns/1ps
module nvh_nvsram_host_tb;
    import nvh_pkg::*;
    localparam int NVW = 20;
    localparam int LIM = 400;
    localparam logic [ADDR_W-1:0] SIG_A = 17'h1_0010;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic strap = 1'b0;
    logic cmd_valid = 1'b0;
    nvh_cmd_t cmd_code = CMD_READ;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_wdata = '0;
    logic cmd_ready_r, rsp_valid_r, init_done_r, mem_ce_n, mem_we_n, mem_oe_n, mem_dq_oe;
    logic [DATA_W-1:0] rsp_rdata_r, mem_dq_out, dq_lvl;
    logic [ADDR_W-1:0] mem_addr;
    logic [3:0] lat = 4'h0;
    int q[$];
    logic [ADDR_W-1:0] al [8];
    int n_store = 0;
    int n_recall = 0;
    logic [7:0] shadow [int];
    logic [7:0] shadow_nv [int];
    int err_count = 0;
    int n_compared = 0;

    initial forever #2 clk_sys = ~clk_sys;

    nvh_nvsram_host #(.NV_WAIT_CYC(NVW)) uut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .autosave_keep_on(strap),
        .cmd_valid(cmd_valid),
        .cmd_code(cmd_code),
        .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata),
        .cmd_ready_r(cmd_ready_r),
        .rsp_valid_r(rsp_valid_r),
        .rsp_rdata_r(rsp_rdata_r),
        .init_done_r(init_done_r),
        .mem_ce_n(mem_ce_n),
        .mem_we_n(mem_we_n),
        .mem_oe_n(mem_oe_n),
        .mem_addr(mem_addr),
        .mem_dq_out(mem_dq_out),
        .mem_dq_oe(mem_dq_oe),
        .mem_dq_in(dq_lvl)
    );

    nvh_nvsram_model u_model (
        .clk_sys(clk_sys),
        .mem_ce_n(mem_ce_n),
        .mem_we_n(mem_we_n),
        .mem_oe_n(mem_oe_n),
        .mem_addr(mem_addr),
        .host_dq(mem_dq_out),
        .host_oe(mem_dq_oe),
        .rd_lat(lat),
        .dq_lvl(dq_lvl)
    );

    task automatic stop_test();
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic mismatch(input string msg);
        err_count++;
        $display("MISMATCH t=%0t %s", $time, msg);
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            mismatch(msg);
        end
    endtask

    task automatic cmp_cnt(input int got, input int exp, input string msg);
        n_compared++;
        if (got != exp) begin
            mismatch(msg);
        end
    endtask

    task automatic cmp_data(input logic [7:0] got, input int exp);
        n_compared++;
        if (got !== 8'(exp)) begin
            mismatch("read data differs");
        end
    endtask

    // oldest note answers each response pulse
    always @(posedge clk_sys) begin
        if (rst_n && rsp_valid_r) begin
            if (q.size() == 0) begin
                mismatch("response with no request");
            end else if (q[0] < 0) begin
                void'(q.pop_front());
            end else begin
                cmp_data(rsp_rdata_r, q.pop_front());
            end
        end
    end

    task automatic wait_init();
        int n;
        n = 0;
        while (!init_done_r && n < LIM) begin
            n++;
            @(posedge clk_sys);
        end
        if (n >= LIM) begin
            mismatch("init sequence timeout");
            stop_test();
        end
    endtask

    task automatic drain();
        int n;
        n = 0;
        while ((q.size() > 0 || !cmd_ready_r) && n < LIM) begin
            n++;
            @(posedge clk_sys);
        end
        if (n >= LIM) begin
            mismatch("responses missing");
            stop_test();
        end
    endtask

    task automatic send(input nvh_cmd_t c, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(posedge clk_sys);
        while (!cmd_ready_r && n < LIM) begin
            n++;
            @(posedge clk_sys);
        end
        cmd_valid <= 1'b0;
        if (n >= LIM) begin
            mismatch("command not taken");
            stop_test();
        end
        if (c == CMD_READ) begin
            q.push_back(int'(shadow[int'(a)]));
        end else begin
            q.push_back(-1);
        end
        if (c == CMD_WRITE) begin
            shadow[int'(a)] = d;
        end
        if (c == CMD_STORE) begin
            shadow_nv = shadow;
            n_store++;
        end
        if (c == CMD_RECALL) begin
            shadow = shadow_nv;
            n_recall++;
        end
        @(posedge clk_sys);
    endtask

    task automatic do_reset(input logic s);
        rst_n <= 1'b0;
        strap <= s;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) begin
            @(posedge clk_sys);
            cmp_bit(mem_ce_n, 1'b1, "chip selected right after reset");
            cmp_bit(cmd_ready_r, 1'b0, "ready right after reset");
            cmp_bit(init_done_r, 1'b0, "init done right after reset");
        end
        wait_init();
        cmp_bit(u_model.as_en, s, "auto save mode not set after reset");
    endtask

    initial begin
        void'($urandom(81764));
        do_reset(1'b1);
        for (int i = 0; i < 8; i++) begin
            al[i] = 17'($urandom) & 17'h1_00FF;
            lat <= 4'($urandom_range(15, 0));
            send(CMD_WRITE, al[i], 8'($urandom));
        end
        for (int i = 0; i < 8; i++) begin
            send(CMD_READ, al[i], 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            send(CMD_WRITE, SIG_A + 17'(i), 8'($urandom));
        end
        send(CMD_STORE, '0, 8'h00);
        for (int i = 0; i < 4; i++) begin
            send(CMD_WRITE, SIG_A + 17'(i), ~shadow[int'(SIG_A) + i]);
        end
        send(CMD_RECALL, '0, 8'h00);
        for (int i = 0; i < 4; i++) begin
            send(CMD_READ, SIG_A + 17'(i), 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            send(CMD_READ, al[i], 8'h00);
        end
        send(CMD_AS_DIS, '0, 8'h00);
        drain();
        cmp_bit(u_model.as_en, 1'b0, "disable command ignored");
        send(CMD_AS_EN, '0, 8'h00);
        drain();
        cmp_bit(u_model.as_en, 1'b1, "enable command ignored");
        do_reset(1'b0);
        send(CMD_WRITE, 17'h0_0020, 8'($urandom));
        send(CMD_READ, 17'h0_0020, 8'h00);
        send(CMD_STORE, '0, 8'h00);
        drain();
        cmp_cnt(u_model.store_cnt, n_store, "save count");
        cmp_cnt(u_model.recall_cnt, n_recall, "recall count");
        cmp_cnt(u_model.abort_cnt, 0, "sequence broken");
        cmp_cnt(u_model.seq_wr, 0, "write inside sequence");
        cmp_cnt(u_model.busy_hit, 0, "access during busy time");
        cmp_cnt(u_model.clash, 0, "data pins driven by both sides");
        cmp_bit(u_model.as_en, 1'b0, "auto save came back after save");
        stop_test();
    end
endmodule
